// ### src/rdt_channel.v
// One reload timer channel: prescaler, edge detector, 16-bit down counter.
// Assumes timer_ext_input synchronous to clk and control ports held steady by the host.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_defines.vh"

module rdt_channel #(
  parameter CNT_W = `RDT_CNT_W
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [CNT_W-1:0] reload_value,
  input  wire             count_enable,
  input  wire             soft_trigger_bit,
  input  wire             clk_source,
  input  wire [1:0]       prescale_sel,
  input  wire [1:0]       start_op,
  input  wire [1:0]       edge_sel,
  input  wire             gate_level,
  input  wire             reload_mode,
  input  wire             wave_init,
  input  wire             flag_clear,
  input  wire             irq_enable,
  input  wire             timer_ext_input,
  output reg  [CNT_W-1:0] count,
  output reg              running,
  output reg              underflow_flag,
  output wire             irq,
  output reg              underflow_pulse,
  output reg              timer_wave_output
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_LOAD  = 3'b010;
  localparam ST_COUNT = 3'b100;

  reg [2:0]            state;
  reg [2:0]            next_state;
  reg [`RDT_PRE_W-1:0] pre_cnt;
  reg                  ext_prev;
  reg                  toggle;

  function edge_hit;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
      case (sel)
        `RDT_EDGE_RISE: edge_hit = ~prev & cur;
        `RDT_EDGE_FALL: edge_hit = prev & ~cur;
        `RDT_EDGE_BOTH: edge_hit = prev ^ cur;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  wire ext_edge = edge_hit(edge_sel, ext_prev, timer_ext_input);

  reg [`RDT_PRE_W-1:0] pre_mask;
  always @*
  begin
    case (prescale_sel)
      `RDT_PRE_DIV8:  pre_mask = `RDT_PRE_MASK8;
      `RDT_PRE_DIV32: pre_mask = `RDT_PRE_MASK32;
      default:        pre_mask = `RDT_PRE_MASK2;
    endcase
  end

  // Software trigger starts every mode; edge start only in internal trigger op
  wire ext_start = (clk_source == `RDT_CLK_INT) && (start_op == `RDT_OP_TRIG)
                   && ext_edge;
  wire trigger   = count_enable && (soft_trigger_bit || ext_start);

  wire gate_ok   = (clk_source != `RDT_CLK_INT) || (start_op != `RDT_OP_GATE)
                   || (timer_ext_input == gate_level);
  wire pre_tick  = (pre_cnt & pre_mask) == pre_mask;
  wire step      = (clk_source == `RDT_CLK_EVENT) ? ext_edge
                   : (pre_tick && gate_ok);
  wire at_zero   = count == `RDT_ALL_ZERO;
  wire uflow     = (state == ST_COUNT) && step && at_zero;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:  if (trigger) next_state = ST_LOAD;
      ST_LOAD:  next_state = ST_COUNT;
      ST_COUNT:
      begin
        if (!count_enable)
          next_state = ST_IDLE;
        else if (trigger)
          next_state = ST_LOAD;
        else if (uflow && !reload_mode)
          next_state = ST_IDLE;
      end
      default:  next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state             <= ST_IDLE;
      count             <= `RDT_ALL_ZERO;
      pre_cnt           <= {`RDT_PRE_W{1'b0}};
      ext_prev          <= 1'b0;
      toggle            <= 1'b0;
      running           <= 1'b0;
      underflow_flag    <= 1'b0;
      underflow_pulse   <= 1'b0;
      timer_wave_output <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      ext_prev        <= timer_ext_input;
      running         <= (next_state != ST_IDLE);
      underflow_pulse <= uflow;
      if (state == ST_LOAD)
        pre_cnt <= {`RDT_PRE_W{1'b0}};
      else
        pre_cnt <= pre_cnt + 1'b1;
      if (state == ST_LOAD)
        count <= reload_value;
      else if (uflow && reload_mode)
        count <= reload_value;
      else if (state == ST_COUNT && step)
        count <= count - 1'b1;
      // Set beats a clear landing in the same cycle
      if (uflow)
        underflow_flag <= 1'b1;
      else if (flag_clear)
        underflow_flag <= 1'b0;
      if (!count_enable)
        toggle <= wave_init;
      else if (uflow)
        toggle <= ~toggle;
      timer_wave_output <= reload_mode ? toggle
                           : (next_state != ST_IDLE);
    end
  end

  assign irq = underflow_flag & irq_enable;

endmodule
`default_nettype wire

// ### src/rdt_defines.vh
// Constants for the two-channel 16-bit reload down timer.
// Assumes inclusion by bare name from the timer sources.
`ifndef RDT_DEFINES_VH
`define RDT_DEFINES_VH

`define RDT_CNT_W        16
`define RDT_ALL_ZERO     16'h0000
`define RDT_ALL_ONES     16'hFFFF
// Prescale select codes and their periods in machine clocks
`define RDT_PRE_DIV2     2'h0
`define RDT_PRE_DIV8     2'h1
`define RDT_PRE_DIV32    2'h2
`define RDT_PRE_W        5
`define RDT_PRE_MASK2    5'h01
`define RDT_PRE_MASK8    5'h07
`define RDT_PRE_MASK32   5'h1F
// Clock source
`define RDT_CLK_INT      1'h0
`define RDT_CLK_EVENT    1'h1
// Internal clock start operation
`define RDT_OP_SOFT      2'h0
`define RDT_OP_TRIG      2'h1
`define RDT_OP_GATE      2'h2
// Edge select
`define RDT_EDGE_NONE    2'h0
`define RDT_EDGE_RISE    2'h1
`define RDT_EDGE_FALL    2'h2
`define RDT_EDGE_BOTH    2'h3
// Least external clock period in machine clocks (other party)
`define RDT_EXT_MIN_PER  8

`endif

// ### src/rdt_timer.v
// Two-channel 16-bit reload down timer, control bits on plain ports.
// Assumes all inputs synchronous to clk; ext clock period >= 8 clocks.
//
// Overview of operation
// - Step from 0000 to FFFF is an underflow, after reload plus one steps.
// - Internal clock mode counts every 2, 8 or 32 machine clocks.
// - Reload mode reloads on underflow and keeps counting.
// - One-shot mode halts on underflow until triggered again.
// - Every underflow can raise an interrupt and start the I/O service.
// - Writing one to the software trigger bit starts counting.
// - Software trigger also works in external trigger and gate operation.
// - External trigger operation starts counting on the selected input edge.
// - Gate operation counts only while input holds the selected level.
// - Event count mode decrements once per selected input edge.
// - Event count supports reload and one-shot; software trigger only.
// - Reload mode output pin toggles at every underflow.
// - One-shot mode output pin is active while counting.
// - Two independent channels, each with own pins, control and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_defines.vh"

module rdt_timer #(
  parameter CNT_W = `RDT_CNT_W
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [CNT_W-1:0] reload_value_ch0,
  input  wire             count_enable_ch0,
  input  wire             soft_trigger_bit_ch0,
  input  wire             clk_source_ch0,
  input  wire [1:0]       prescale_sel_ch0,
  input  wire [1:0]       start_op_ch0,
  input  wire [1:0]       edge_sel_ch0,
  input  wire             gate_level_ch0,
  input  wire             reload_mode_ch0,
  input  wire             wave_init_ch0,
  input  wire             flag_clear_ch0,
  input  wire             irq_enable_ch0,
  input  wire             timer_ext_input_ch0,
  output wire [CNT_W-1:0] count_ch0,
  output wire             running_ch0,
  output wire             underflow_flag_ch0,
  output wire             irq_ch0,
  output wire             intelligent_io_service_ch0,
  output wire             timer_wave_output_ch0,
  input  wire [CNT_W-1:0] reload_value_ch1,
  input  wire             count_enable_ch1,
  input  wire             soft_trigger_bit_ch1,
  input  wire             clk_source_ch1,
  input  wire [1:0]       prescale_sel_ch1,
  input  wire [1:0]       start_op_ch1,
  input  wire [1:0]       edge_sel_ch1,
  input  wire             gate_level_ch1,
  input  wire             reload_mode_ch1,
  input  wire             wave_init_ch1,
  input  wire             flag_clear_ch1,
  input  wire             irq_enable_ch1,
  input  wire             timer_ext_input_ch1,
  output wire [CNT_W-1:0] count_ch1,
  output wire             running_ch1,
  output wire             underflow_flag_ch1,
  output wire             irq_ch1,
  output wire             intelligent_io_service_ch1,
  output wire             timer_wave_output_ch1
);

  // Two independent copies share nothing but clock and reset
  rdt_channel #(.CNT_W(CNT_W)) u_ch0 (
    .clk               (clk),
    .rst_n             (rst_n),
    .reload_value      (reload_value_ch0),
    .count_enable      (count_enable_ch0),
    .soft_trigger_bit  (soft_trigger_bit_ch0),
    .clk_source        (clk_source_ch0),
    .prescale_sel      (prescale_sel_ch0),
    .start_op          (start_op_ch0),
    .edge_sel          (edge_sel_ch0),
    .gate_level        (gate_level_ch0),
    .reload_mode       (reload_mode_ch0),
    .wave_init         (wave_init_ch0),
    .flag_clear        (flag_clear_ch0),
    .irq_enable        (irq_enable_ch0),
    .timer_ext_input   (timer_ext_input_ch0),
    .count             (count_ch0),
    .running           (running_ch0),
    .underflow_flag    (underflow_flag_ch0),
    .irq               (irq_ch0),
    .underflow_pulse   (intelligent_io_service_ch0),
    .timer_wave_output (timer_wave_output_ch0)
  );

  rdt_channel #(.CNT_W(CNT_W)) u_ch1 (
    .clk               (clk),
    .rst_n             (rst_n),
    .reload_value      (reload_value_ch1),
    .count_enable      (count_enable_ch1),
    .soft_trigger_bit  (soft_trigger_bit_ch1),
    .clk_source        (clk_source_ch1),
    .prescale_sel      (prescale_sel_ch1),
    .start_op          (start_op_ch1),
    .edge_sel          (edge_sel_ch1),
    .gate_level        (gate_level_ch1),
    .reload_mode       (reload_mode_ch1),
    .wave_init         (wave_init_ch1),
    .flag_clear        (flag_clear_ch1),
    .irq_enable        (irq_enable_ch1),
    .timer_ext_input   (timer_ext_input_ch1),
    .count             (count_ch1),
    .running           (running_ch1),
    .underflow_flag    (underflow_flag_ch1),
    .irq               (irq_ch1),
    .underflow_pulse   (intelligent_io_service_ch1),
    .timer_wave_output (timer_wave_output_ch1)
  );

endmodule
`default_nettype wire

// ### testbench/rdt_ext_src.sv
// Far-side source for one timer input pin: a steady level or an edge train.
// Assumes half is at least 4, so the pin period never drops below 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module rdt_ext_src (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic       lvl,
  input  wire logic [3:0] half,
  output var  logic       pin
);
  logic [3:0] cnt = 4'h0;
  initial pin = 1'b0;
  always @(posedge clk)
  begin
    cnt <= (run && cnt != half - 4'h1) ? cnt + 4'h1 : 4'h0;
    if (!run)
      pin <= lvl;
    else if (cnt == half - 4'h1)
      pin <= ~pin;
  end
endmodule
`default_nettype wire

// ### testbench/rdt_timer_assertions.sv
// Concurrent checks on channel 0 of the reload down timer.
// Assumes control inputs stay steady while the channel counts.
`timescale 1ns/1ps
`default_nettype none
module rdt_timer_chk #(parameter CNT_W = 16) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [CNT_W-1:0] reload_value_ch0,
  input wire logic             count_enable_ch0,
  input wire logic             soft_trigger_bit_ch0,
  input wire logic             reload_mode_ch0,
  input wire logic             flag_clear_ch0,
  input wire logic             irq_enable_ch0,
  input wire logic [CNT_W-1:0] count_ch0,
  input wire logic             running_ch0,
  input wire logic             underflow_flag_ch0,
  input wire logic             irq_ch0,
  input wire logic             intelligent_io_service_ch0,
  input wire logic             timer_wave_output_ch0
);
  wire io = intelligent_io_service_ch0;
  wire rl = reload_mode_ch0;
  wire wv = timer_wave_output_ch0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence load_s;
    running_ch0 ##1 count_ch0 == reload_value_ch0;
  endsequence
  trig_load_a: assert property (count_enable_ch0 && soft_trigger_bit_ch0 |=> load_s)
    else $error("trigger did not load the counter");
  uf_zero_a: assert property (io |-> $past(count_ch0) == 16'h0000)
    else $error("underflow pulse without a step from zero");
  uf_flag_a: assert property (io |-> underflow_flag_ch0)
    else $error("underflow pulse without the flag");
  reload_back_a: assert property (io && rl |-> count_ch0 == reload_value_ch0)
    else $error("reload value not restored");
  shot_stop_a: assert property (io && !rl |-> !running_ch0 && count_ch0 == 16'hFFFF)
    else $error("one-shot kept running");
  // Wave pin is registered from the toggle, so it flips one cycle after the pulse
  wave_toggle_a: assert property (io && rl |=> wv != $past(wv))
    else $error("wave did not toggle");
  shot_wave_a: assert property (!rl && running_ch0 |-> wv)
    else $error("wave low while running");
  irq_gate_a: assert property (irq_ch0 == (underflow_flag_ch0 && irq_enable_ch0))
    else $error("irq not flag and enable");
  flag_hold_a: assert property (underflow_flag_ch0 && !flag_clear_ch0 |=> underflow_flag_ch0)
    else $error("flag dropped without clear");
endmodule
bind rdt_timer rdt_timer_chk #(.CNT_W(CNT_W)) rdt_timer_chk_i (.*);
`default_nettype wire

// ### testbench/test_reload_down_timer.sv
// Self-checking bench for the two-channel reload down timer.
// Assumes rdt_ext_src models the input pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module test_reload_down_timer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] rv [2];
  logic [1:0]  ps [2], so [2], es [2];
  logic        ce [2], st [2], cs [2], gl [2], rm [2], wi [2], fc [2], ie [2], run [2], lvl [2];
  logic [3:0]  hf [2];
  wire  [15:0] cnt [2];
  wire         rn [2], fl [2], iq [2], io [2], wv [2], pin [2];
  logic [31:0] q [2][$];
  int          fail_count = 0, checked = 0, cyc = 0, last [2];
  always #50 clk = ~clk;
  for (genvar c = 0; c < 2; c++)
  begin
    rdt_ext_src rdt_ext_src_i (.clk(clk), .run(run[c]), .lvl(lvl[c]), .half(hf[c]), .pin(pin[c]));
  end
  rdt_timer rdt_timer_i (.clk(clk), .rst_n(rst_n), .reload_value_ch0(rv[0]),
    .count_enable_ch0(ce[0]), .soft_trigger_bit_ch0(st[0]), .clk_source_ch0(cs[0]),
    .prescale_sel_ch0(ps[0]), .start_op_ch0(so[0]), .edge_sel_ch0(es[0]), .gate_level_ch0(gl[0]),
    .reload_mode_ch0(rm[0]), .wave_init_ch0(wi[0]), .flag_clear_ch0(fc[0]), .irq_enable_ch0(ie[0]),
    .timer_ext_input_ch0(pin[0]), .count_ch0(cnt[0]), .running_ch0(rn[0]), .irq_ch0(iq[0]),
    .underflow_flag_ch0(fl[0]), .intelligent_io_service_ch0(io[0]), .timer_wave_output_ch0(wv[0]),
    .reload_value_ch1(rv[1]), .count_enable_ch1(ce[1]), .soft_trigger_bit_ch1(st[1]),
    .clk_source_ch1(cs[1]), .prescale_sel_ch1(ps[1]), .start_op_ch1(so[1]), .edge_sel_ch1(es[1]),
    .gate_level_ch1(gl[1]), .reload_mode_ch1(rm[1]), .wave_init_ch1(wi[1]), .flag_clear_ch1(fc[1]),
    .irq_enable_ch1(ie[1]), .timer_ext_input_ch1(pin[1]), .count_ch1(cnt[1]), .running_ch1(rn[1]),
    .irq_ch1(iq[1]), .underflow_flag_ch1(fl[1]), .intelligent_io_service_ch1(io[1]),
    .timer_wave_output_ch1(wv[1]));
  task cmp(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim();
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // Enable dropped a cycle before the mode changes, so no stale state mixes in
  task cfg(int c, logic s, logic [1:0] p, logic [1:0] o, logic [1:0] e, logic r, logic [15:0] v);
    @(posedge clk);
    ce[c] <= 1'b0;
    @(posedge clk);
    {cs[c], ps[c], so[c], es[c], rm[c], rv[c]} <= {s, p, o, e, r, v};
    @(posedge clk);
    ce[c] <= 1'b1;
  endtask
  task trig(int c);
    @(posedge clk);
    st[c] <= 1'b1;
    @(posedge clk);
    st[c] <= 1'b0;
  endtask
  task note(int c, logic [15:0] gap, logic [15:0] v);
    q[c].push_back({gap, v});
  endtask
  task drain(int c);
    // Falling edge avoids racing the watcher's pop; enable then drops a fixed cycle later
    repeat (3000) if (q[c].size() != 0) @(negedge clk);
    if (q[c].size() != 0)
    begin
      cmp("drain", 0, q[c].size());
      end_sim();
    end
  endtask
  always @(posedge clk)
  begin
    logic [31:0] e;
    cyc <= cyc + 1;
    for (int c = 0; c < 2; c++)
      if (io[c] === 1'b1)
      begin
        if (q[c].size() == 0)
          cmp("extra underflow", 0, 1);
        else
        begin
          e = q[c].pop_front();
          cmp("count", e[15:0], cnt[c]);
          if (e[31:16] != 16'hFFFF)
            cmp("interval", e[31:16], cyc - last[c]);
        end
        last[c] = cyc;
      end
  end
  initial
  begin
    int r;
    for (int c = 0; c < 2; c++)
    begin
      {rv[c], ps[c], so[c], es[c], hf[c]} = '0;
      {ce[c], st[c], cs[c], gl[c], rm[c], wi[c], fc[c], ie[c], run[c], lvl[c]} = '0;
    end
    r = $urandom(72220);
    tick(8);
    cmp("reset ch0", 0, {rn[0], fl[0], iq[0], io[0], wv[0], cnt[0]});
    cmp("reset ch1", 0, {rn[1], fl[1], iq[1], io[1], wv[1], cnt[1]});
    rst_n <= 1'b1;
    ie[0] <= 1'b1;
    ie[1] <= 1'b1;
    wi[0] <= 1'b1;
    hf[1] <= 4'h5;
    for (int p = 0; p < 3; p++)
    begin
      r = 1 + $urandom % 4;
      cfg(0, 1'b0, p[1:0], 2'h0, 2'h0, 1'b1, r[15:0]);
      trig(0);
      cmp("wave init", 1, wv[0]);
      note(0, 16'hFFFF, r[15:0]);
      repeat (2) note(0, 16'((r + 1) * (2 << (2 * p))), r[15:0]);
      drain(0);
    end
    cfg(0, 1'b0, 2'h1, 2'h0, 2'h0, 1'b0, r[15:0]);
    repeat (2)
    begin
      trig(0);
      note(0, 16'hFFFF, 16'hFFFF);
      drain(0);
      tick(40);
      cmp("running", 0, rn[0]);
    end
    cmp("flag irq", 2'h3, {fl[0], iq[0]});
    @(posedge clk);
    fc[0] <= 1'b1;
    ie[0] <= 1'b0;
    @(posedge clk);
    fc[0] <= 1'b0;
    tick(1);
    cmp("cleared", 0, {fl[0], iq[0]});
    for (int e = 1; e < 4; e++)
    begin
      cfg(0, 1'b0, 2'h0, 2'h1, e[1:0], 1'b0, 16'h0001);
      lvl[0] <= (e == 2);
      tick(3);
      lvl[0] <= (e != 2);
      note(0, 16'hFFFF, 16'hFFFF);
      drain(0);
    end
    cfg(0, 1'b0, 2'h0, 2'h1, 2'h1, 1'b0, 16'h0001);
    lvl[0] <= 1'b0;
    tick(4);
    cmp("wrong edge", 0, rn[0]);
    gl[0] <= 1'b1;
    cfg(0, 1'b0, 2'h0, 2'h2, 2'h0, 1'b0, r[15:0]);
    trig(0);
    tick(20);
    cmp("gated count", r, cnt[0]);
    lvl[0] <= 1'b1;
    note(0, 16'hFFFF, 16'hFFFF);
    drain(0);
    @(posedge clk);
    run[1] <= 1'b1;
    cfg(1, 1'b1, 2'h0, 2'h1, 2'h3, 1'b1, 16'h0002);
    tick(30);
    cmp("event idle", 0, rn[1]);
    for (int e = 1; e < 4; e++)
    begin
      r = 1 + $urandom % 4;
      cfg(1, 1'b1, 2'h0, 2'h0, e[1:0], e != 2, r[15:0]);
      trig(1);
      note(1, 16'hFFFF, (e == 2) ? 16'hFFFF : r[15:0]);
      if (e != 2)
        note(1, 16'((r + 1) * (e == 3 ? 5 : 10)), r[15:0]);
      drain(1);
    end
    cmp("ch1 flag irq", 2'h3, {fl[1], iq[1]});
    end_sim();
  end
endmodule
`default_nettype wire
